// ==== src/omc_defs.svh ====
/*
  Constants for the output cell block: fuse codes, field positions and
  reset values. Assumes it is included by bare name from src/.
*/
// Overview of operation
// - Unprogrammed fuse (A) makes a connection active; programmed fuse makes it inactive.
// - Product term with both true and complement inputs intact stays inactive.
// - Register-type fuse: A gives D flip-flop, programmed gives J-K flip-flop.
// - Configuration fuse: A gives registered output; programmed gives combinatorial plus buried.
// - Output polarity applies only to the combinatorial output path.
// - Register updates on rising edge of external clock (A) or cell clock.
// - Any cell can capture its pin value as a registered input.
// - Output enable: from active-low pin, from product term, or always enabled.
// - The two extra bidirectional pins take enable only from their product terms.
// - After power-up every flip-flop is 0, so registered pins show high.
// - Preset term forces 1, reset term forces 0, without waiting for a clock.
// - J-K holds, clears, sets per J and K; pin shows complement; D follows D.
// - With preset and reset both asserted the register reads high.
`ifndef OMC_DEFS_SVH
`define OMC_DEFS_SVH
`define OMC_FUSE_A 1'b0
`define OMC_FUSE_PROG 1'b1
`define OMC_REG_RESET 1'b0
`define OMC_NCELL 10
`define OMC_ADDR_CFG 32'h0000_0000
`define OMC_ADDR_POL 32'h0000_0004
`define OMC_ADDR_CTL 32'h0000_0008
`define OMC_ADDR_STAT 32'h0000_000c
`define OMC_ADDR_PIN 32'h0000_0010
`define OMC_ADDR_XB 32'h0000_0014
`define OMC_CFG_REGSEL_LSB 0
`define OMC_CFG_CONF_LSB 10
`define OMC_CFG_CLK_LSB 20
`define OMC_CTL_OEC_LSB 0
`define OMC_CTL_EN_LSB 10
`define OMC_CFG_RST 32'h0000_0000
`define OMC_RESP_OKAY 2'b00
`define OMC_RESP_SLVERR 2'b10
`endif

// ==== src/omc_pkg.sv ====
/*
  Types shared by the output cell block.
  Assumes omc_defs.svh sits beside it.
*/
package omc_pkg;
  typedef enum logic [1:0] {
    OMC_OE_PIN,
    OMC_OE_TERM,
    OMC_OE_ALWAYS
  } omc_oe_mode_t;
  typedef enum logic {
    OMC_BUS_IDLE,
    OMC_BUS_RESP
  } omc_bus_state_t;
endpackage

// ==== src/omc_cell_if.sv ====
/*
  Carrier between the top and its cell register bank: per-cell drive terms
  and results. Assumes one clock domain.
*/
`timescale 1ns/100ps
interface omc_cell_if #(parameter int N = 10);
  logic [N-1:0] jd;
  logic [N-1:0] k;
  logic [N-1:0] load;
  logic [N-1:0] pin_in;
  logic [N-1:0] preset_term;
  logic [N-1:0] reset_term;
  logic [N-1:0] clk_sel_ext;
  logic [N-1:0] is_d;
  logic [N-1:0] cell_clock;
  logic ext_clock;
  logic [N-1:0] q;
  modport top (output jd, k, load, pin_in, preset_term, reset_term, clk_sel_ext,
    is_d, cell_clock, ext_clock, input q);
  modport bank (input jd, k, load, pin_in, preset_term, reset_term, clk_sel_ext,
    is_d, cell_clock, ext_clock, output q);
endinterface

// ==== src/omc_cell_bank.sv ====
/*
  Register bank of the output cells, one flip-flop per cell.
  Assumes all inputs are already synchronised to clk_sys; clock edges arrive
  as level samples and are edge-detected here.
*/
`timescale 1ns/100ps
`include "omc_defs.svh"
module omc_cell_bank #(
  parameter int N = `OMC_NCELL
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Cell terms
  omc_cell_if.bank cif
);
  logic [N-1:0] q_ff;
  logic [N-1:0] nxt_q;
  logic [N-1:0] clk_last_ff;
  logic [N-1:0] nxt_clk_last;
  logic [N-1:0] clk_lvl;

  assign cif.q = q_ff;

  // -------------------------------------------------------------
  // Per-cell next state
  // -------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cell
      // Select clock source per cell
      assign clk_lvl[g] = cif.clk_sel_ext[g] ? cif.ext_clock : cif.cell_clock[g];
      always_comb begin
        nxt_clk_last[g] = clk_lvl[g];
        nxt_q[g] = q_ff[g];
        // Preset wins while both held, so Q reads high
        if (cif.preset_term[g]) begin
          nxt_q[g] = 1'b1;
        end else if (cif.reset_term[g]) begin
          nxt_q[g] = 1'b0;
        end else if (clk_lvl[g] && !clk_last_ff[g]) begin
          if (cif.load[g]) begin
            nxt_q[g] = cif.pin_in[g];
          end else if (cif.is_d[g]) begin
            nxt_q[g] = cif.jd[g];
          end else begin
            case ({cif.jd[g], cif.k[g]})
              2'b01: nxt_q[g] = 1'b0;
              2'b10: nxt_q[g] = 1'b1;
              2'b11: nxt_q[g] = ~q_ff[g];
              default: nxt_q[g] = q_ff[g];
            endcase
          end
        end
      end
    end
  endgenerate

  // Register; flops clear to zero at reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q_ff <= '0;
      clk_last_ff <= '0;
    end else begin
      q_ff <= nxt_q;
      clk_last_ff <= nxt_clk_last;
    end
  end

  // Preset forces the register high by the next cycle
  property p_preset;
    @(posedge clk_sys) disable iff (reset) cif.preset_term[0] |=> q_ff[0];
  endproperty
  a_preset: assert property (p_preset) else $error("preset did not set");

  property p_reset_only;
    @(posedge clk_sys) disable iff (reset)
      (cif.reset_term[0] && !cif.preset_term[0]) |=> !q_ff[0];
  endproperty
  a_reset_only: assert property (p_reset_only) else $error("reset did not clear");

  property p_jk_toggle;
    @(posedge clk_sys) disable iff (reset)
      (!cif.preset_term[0] && !cif.reset_term[0] && !cif.is_d[0] && !cif.load[0]
       && clk_lvl[0] && !clk_last_ff[0] && cif.jd[0] && cif.k[0])
      |=> q_ff[0] != $past(q_ff[0]);
  endproperty
  a_jk_toggle: assert property (p_jk_toggle) else $error("jk did not toggle");

  property p_hold_no_edge;
    @(posedge clk_sys) disable iff (reset)
      (!cif.preset_term[0] && !cif.reset_term[0] && !(clk_lvl[0] && !clk_last_ff[0]))
      |=> $stable(q_ff[0]);
  endproperty
  a_hold_no_edge: assert property (p_hold_no_edge) else $error("q moved without edge");
endmodule

// ==== src/omc_top.sv ====
/*
  Output cell logic of a programmable sequencer: ten cells with D or J-K
  registers, registered or combinatorial outputs, selectable clocks, enable
  control, preload and preset/reset, plus two extra bidirectional pins.
  Fuse settings are held in AXI4-Lite registers. Pins and external clock
  arrive asynchronously and are synchronised by two flops; array product
  terms come from logic on clk_sys.
*/
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "omc_defs.svh"
module omc_top #(
  parameter int N = `OMC_NCELL
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Product terms from the array, raw (one set per cell, plus one pair for the two extra pins)
  input wire logic [N-1:0] term_data_pos,
  input wire logic [N-1:0] term_data_neg,
  input wire logic [N-1:0] term_data_fuse_pos,
  input wire logic [N-1:0] term_data_fuse_neg,
  input wire logic [N-1:0] term_k,
  input wire logic [N-1:0] term_comb,
  input wire logic [N-1:0] cell_clock,
  input wire logic [N-1:0] preset_term,
  input wire logic [N-1:0] reset_term,
  input wire logic [N-1:0] load_term,
  input wire logic [N-1:0] oe_term,
  input wire logic [1:0] xb_out_term,
  input wire logic [1:0] xb_oe_term,
  // Pins
  input wire logic ext_clock_pin,
  input wire logic oe_pin_n,
  input wire logic [N-1:0] cell_pin_in,
  output logic [N-1:0] cell_pin_out,
  output logic [N-1:0] cell_pin_oe,
  input wire logic extra_bidir_pin_zero_in,
  output logic extra_bidir_pin_zero_out,
  output logic extra_bidir_pin_zero_oe,
  input wire logic extra_bidir_pin_one_in,
  output logic extra_bidir_pin_one_out,
  output logic extra_bidir_pin_one_oe,
  // Feedback to the array
  output logic [N-1:0] reg_feedback,
  output logic [N-1:0] pin_feedback,
  output logic [1:0] xb_feedback
);
  // -------------------------------------------------------------
  // Synchronisers for pins and the external clock
  // -------------------------------------------------------------
  logic [N+3:0] sync1_ff;
  logic [N+3:0] sync2_ff;
  logic [N+3:0] nxt_sync1;
  logic [N-1:0] pin_s;
  logic ext_clk_s;
  logic oe_n_s;
  logic [1:0] xb_in_s;

  // Raw pins gathered for the two-flop stage
  always_comb begin
    nxt_sync1 = {extra_bidir_pin_one_in, extra_bidir_pin_zero_in, oe_pin_n,
      ext_clock_pin, cell_pin_in};
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      // Enable pin idles high; a zero here would switch the cells on after reset
      sync1_ff <= {2'b00, 1'b1, {(N+1){1'b0}}};
      sync2_ff <= {2'b00, 1'b1, {(N+1){1'b0}}};
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= sync1_ff;
    end
  end
  assign pin_s = sync2_ff[N-1:0];
  assign ext_clk_s = sync2_ff[N];
  assign oe_n_s = sync2_ff[N+1];
  assign xb_in_s = sync2_ff[N+3:N+2];

  // -------------------------------------------------------------
  // Fuse registers
  // -------------------------------------------------------------
  // Fuse value 0 means unprogrammed (A), so reset gives the shipped state
  logic [31:0] cfg_ff;
  logic [31:0] nxt_cfg;
  logic [31:0] ctl_ff;
  logic [31:0] nxt_ctl;
  logic [N-1:0] pol_ff;
  logic [N-1:0] nxt_pol;
  logic [N-1:0] regsel_prog;
  logic [N-1:0] conf_prog;
  logic [N-1:0] clk_prog;
  logic [N-1:0] oec_prog;
  logic [N-1:0] en_prog;
  assign regsel_prog = cfg_ff[`OMC_CFG_REGSEL_LSB +: N];
  assign conf_prog = cfg_ff[`OMC_CFG_CONF_LSB +: N];
  assign clk_prog = cfg_ff[`OMC_CFG_CLK_LSB +: N];
  assign oec_prog = ctl_ff[`OMC_CTL_OEC_LSB +: N];
  assign en_prog = ctl_ff[`OMC_CTL_EN_LSB +: N];

  // -------------------------------------------------------------
  // AXI4-Lite slave
  // -------------------------------------------------------------
  omc_pkg::omc_bus_state_t wst_ff, nxt_wst, rst_ff, nxt_rst;
  logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
  logic [31:0] awaddr_ff, nxt_awaddr, wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] merged;
  logic [N-1:0] q;

  // Write path: take address and data in either order, answer after both
  always_comb begin
    nxt_wst = wst_ff;
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bresp = bresp_ff;
    nxt_cfg = cfg_ff;
    nxt_ctl = ctl_ff;
    nxt_pol = pol_ff;
    merged = 32'h0000_0000;
    case (wst_ff)
      omc_pkg::OMC_BUS_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          nxt_aw_got = 1'b1;
          nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          nxt_w_got = 1'b1;
          nxt_wdata = s_axi_wdata;
          nxt_wstrb = s_axi_wstrb;
        end
        if (aw_got_ff && w_got_ff) begin
          nxt_bresp = `OMC_RESP_OKAY;
          for (int b = 0; b < 4; b++) begin
            merged[b*8 +: 8] = wstrb_ff[b] ? wdata_ff[b*8 +: 8] : 8'h00;
          end
          case (awaddr_ff)
            `OMC_ADDR_CFG: begin
              for (int b = 0; b < 4; b++) begin
                if (wstrb_ff[b]) nxt_cfg[b*8 +: 8] = merged[b*8 +: 8];
              end
            end
            `OMC_ADDR_CTL: begin
              for (int b = 0; b < 4; b++) begin
                if (wstrb_ff[b]) nxt_ctl[b*8 +: 8] = merged[b*8 +: 8];
              end
            end
            `OMC_ADDR_POL: begin
              if (wstrb_ff[0]) nxt_pol[7:0] = merged[7:0];
              if (wstrb_ff[1]) nxt_pol[N-1:8] = merged[N-1:8];
            end
            `OMC_ADDR_STAT, `OMC_ADDR_PIN, `OMC_ADDR_XB: nxt_bresp = `OMC_RESP_OKAY;
            default: nxt_bresp = `OMC_RESP_SLVERR;
          endcase
          nxt_aw_got = 1'b0;
          nxt_w_got = 1'b0;
          nxt_wst = omc_pkg::OMC_BUS_RESP;
        end
      end
      omc_pkg::OMC_BUS_RESP: begin
        if (s_axi_bready) nxt_wst = omc_pkg::OMC_BUS_IDLE;
      end
      default: nxt_wst = omc_pkg::OMC_BUS_IDLE;
    endcase
  end

  // Read path: one cycle to register the data, then hold until rready
  always_comb begin
    nxt_rst = rst_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    case (rst_ff)
      omc_pkg::OMC_BUS_IDLE: begin
        if (s_axi_arvalid && s_axi_arready) begin
          nxt_rst = omc_pkg::OMC_BUS_RESP;
          nxt_rresp = `OMC_RESP_OKAY;
          case (s_axi_araddr)
            `OMC_ADDR_CFG: nxt_rdata = cfg_ff;
            `OMC_ADDR_CTL: nxt_rdata = ctl_ff;
            `OMC_ADDR_POL: nxt_rdata = {{(32-N){1'b0}}, pol_ff};
            `OMC_ADDR_STAT: nxt_rdata = {{(32-N){1'b0}}, q};
            `OMC_ADDR_PIN: nxt_rdata = {{(32-N){1'b0}}, pin_s};
            `OMC_ADDR_XB: nxt_rdata = {30'h0000_0000, xb_in_s};
            default: begin
              nxt_rdata = 32'h0000_0000;
              nxt_rresp = `OMC_RESP_SLVERR;
            end
          endcase
        end
      end
      omc_pkg::OMC_BUS_RESP: begin
        if (s_axi_rready) nxt_rst = omc_pkg::OMC_BUS_IDLE;
      end
      default: nxt_rst = omc_pkg::OMC_BUS_IDLE;
    endcase
  end

  // Bus and fuse state registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wst_ff <= omc_pkg::OMC_BUS_IDLE;
      rst_ff <= omc_pkg::OMC_BUS_IDLE;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 32'h0000_0000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bresp_ff <= 2'b00;
      rresp_ff <= 2'b00;
      rdata_ff <= 32'h0000_0000;
      cfg_ff <= `OMC_CFG_RST;
      ctl_ff <= `OMC_CFG_RST;
      pol_ff <= '0;
    end else begin
      wst_ff <= nxt_wst;
      rst_ff <= nxt_rst;
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bresp_ff <= nxt_bresp;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      cfg_ff <= nxt_cfg;
      ctl_ff <= nxt_ctl;
      pol_ff <= nxt_pol;
    end
  end
  // Ready flags are register-derived; address and data are taken once each
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= (nxt_wst == omc_pkg::OMC_BUS_IDLE) && !nxt_aw_got;
      s_axi_wready <= (nxt_wst == omc_pkg::OMC_BUS_IDLE) && !nxt_w_got;
      s_axi_arready <= (nxt_rst == omc_pkg::OMC_BUS_IDLE);
    end
  end
  assign s_axi_bvalid = (wst_ff == omc_pkg::OMC_BUS_RESP);
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = (rst_ff == omc_pkg::OMC_BUS_RESP);
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // -------------------------------------------------------------
  // Cell data path
  // -------------------------------------------------------------
  omc_cell_if #(.N(N)) cif ();
  logic [N-1:0] jd_term;
  logic [N-1:0] oe_now;
  logic [N-1:0] out_now;
  logic [N-1:0] pin_out_ff, nxt_pin_out, pin_oe_ff, nxt_pin_oe;
  logic [1:0] xb_out_ff, nxt_xb_out, xb_oe_ff, nxt_xb_oe;

  // Data term: a gate with both polarities intact never fires
  assign jd_term = (term_data_pos & ~term_data_fuse_pos) |
    (term_data_neg & ~term_data_fuse_neg);
  assign cif.jd = jd_term & ~(~term_data_fuse_pos & ~term_data_fuse_neg);
  assign cif.k = term_k;
  assign cif.is_d = ~regsel_prog;
  assign cif.clk_sel_ext = ~clk_prog;
  assign cif.cell_clock = cell_clock;
  assign cif.ext_clock = ext_clk_s;
  assign cif.preset_term = preset_term;
  assign cif.reset_term = reset_term;
  // Preload only while the driver is off; the far side also keeps it off
  assign cif.load = load_term & ~oe_now;
  assign cif.pin_in = pin_s;
  assign q = cif.q;

  omc_cell_bank #(.N(N)) i_omc_cell_bank (
    .clk_sys(clk_sys),
    .reset(reset),
    .cif(cif.bank)
  );

  // Enable select and output mux per cell
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_out
      always_comb begin
        if (!oec_prog[g] && en_prog[g]) begin
          oe_now[g] = 1'b1;
        end else if (!oec_prog[g]) begin
          oe_now[g] = !oe_n_s;
        end else begin
          oe_now[g] = oe_term[g];
        end
        if (!conf_prog[g]) begin
          out_now[g] = ~q[g];
        end else begin
          out_now[g] = term_comb[g] ^ pol_ff[g];
        end
      end
    end
  endgenerate

  // Pin outputs registered; extra pins ignore the shared enable pin
  always_comb begin
    nxt_pin_out = out_now;
    nxt_pin_oe = oe_now;
    nxt_xb_out = xb_out_term;
    nxt_xb_oe = xb_oe_term;
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_out_ff <= '1;
      pin_oe_ff <= '0;
      xb_out_ff <= 2'b00;
      xb_oe_ff <= 2'b00;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      xb_out_ff <= nxt_xb_out;
      xb_oe_ff <= nxt_xb_oe;
    end
  end
  assign cell_pin_out = pin_out_ff;
  assign cell_pin_oe = pin_oe_ff;
  assign extra_bidir_pin_zero_out = xb_out_ff[0];
  assign extra_bidir_pin_zero_oe = xb_oe_ff[0];
  assign extra_bidir_pin_one_out = xb_out_ff[1];
  assign extra_bidir_pin_one_oe = xb_oe_ff[1];
  assign reg_feedback = q;
  assign pin_feedback = pin_s;
  assign xb_feedback = xb_in_s;

  // Extra pins follow only their own terms
  property p_xb_oe;
    @(posedge clk_sys) disable iff (reset) xb_oe_term[0] |=> extra_bidir_pin_zero_oe;
  endproperty
  a_xb_oe: assert property (p_xb_oe) else $error("extra pin enable wrong");

  property p_reg_pin;
    @(posedge clk_sys) disable iff (reset) !conf_prog[0] |=> cell_pin_out[0] == !$past(q[0]);
  endproperty
  a_reg_pin: assert property (p_reg_pin) else $error("registered pin not inverted");

  property p_pol;
    @(posedge clk_sys) disable iff (reset)
      conf_prog[0] |=> cell_pin_out[0] == ($past(term_comb[0]) ^ $past(pol_ff[0]));
  endproperty
  a_pol: assert property (p_pol) else $error("polarity wrong");

  property p_oe_pin;
    @(posedge clk_sys) disable iff (reset)
      (!oec_prog[0] && !en_prog[0]) |=> cell_pin_oe[0] == !$past(oe_n_s);
  endproperty
  a_oe_pin: assert property (p_oe_pin) else $error("pin enable wrong");

  property p_gate_off;
    @(posedge clk_sys) disable iff (reset)
      (!term_data_fuse_pos[0] && !term_data_fuse_neg[0]) |-> !cif.jd[0];
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("dual-fuse gate active");
endmodule

// ==== verif/omc_board_model.sv ====
/*
  Board beside the output cells: external clock, shared enable pin, pin levels.
  Assumes it shares clk_sys with the block and is driven through its tasks.
*/
`timescale 1ns/100ps
module omc_board_model #(
  parameter int N = 10
) (
  // Clock
  input wire logic clk_sys,
  // Cell pin drive from the block
  input wire logic [N-1:0] cell_pin_out,
  input wire logic [N-1:0] cell_pin_oe,
  // Board outputs
  output logic ext_clock_pin,
  output logic oe_pin_n,
  output logic [N-1:0] cell_pin_in
);
  logic drv_en;
  logic [N-1:0] drv;
  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  // A pin that neither cell nor board drives shows the inverse of the board value, so stale data never passes
  assign cell_pin_in = (cell_pin_oe & cell_pin_out) | (~cell_pin_oe & {N{drv_en}} & drv) |
    (~cell_pin_oe & ~{N{drv_en}} & ~drv);
  // Quiet board at time zero
  initial begin
    ext_clock_pin = 1'b0;
    oe_pin_n = 1'b1;
    drv_en = 1'b0;
    drv = '0;
  end
  // Board drives the pins only while the shared enable keeps the cells off
  task automatic set_pins(input logic oen, input logic en, input logic [N-1:0] v);
    @(posedge clk_sys);
    oe_pin_n <= oen;
    drv_en <= en & oen;
    drv <= v;
  endtask
  // Clock stands low between pulses; six cycles a side clear the two-flop sync
  task automatic ext_pulse();
    @(posedge clk_sys);
    ext_clock_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    ext_clock_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule

// ==== verif/omc_top_tb.sv ====
/*
  Self-checking bench of the output cell block over AXI4-Lite.
  Assumes omc_defs.svh on the include path and the board model beside it.
*/
`timescale 1ns/100ps
`include "omc_defs.svh"
`define CHK(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) begin \
      n_errors++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
    end \
  end
module omc_top_tb;
  localparam int N = 10;
  logic clk_sys, reset;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, xb_out_term, xb_oe_term, xb_feedback, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [N-1:0] term_data_pos, term_data_neg, term_data_fuse_pos, term_data_fuse_neg;
  logic [N-1:0] term_k, term_comb, cell_clock, preset_term, reset_term, load_term, oe_term;
  logic [N-1:0] cell_pin_in, cell_pin_out, cell_pin_oe, reg_feedback, pin_feedback, e;
  logic ext_clock_pin, oe_pin_n, extra_bidir_pin_zero_in, extra_bidir_pin_zero_out;
  logic extra_bidir_pin_zero_oe, extra_bidir_pin_one_in, extra_bidir_pin_one_out;
  logic extra_bidir_pin_one_oe;
  logic [N-1:0] jv [3];
  logic [N-1:0] kv [3];
  int n_errors, checks_done;

  omc_top #(.N(N)) i_omc_top (.*);
  omc_board_model #(.N(N)) i_omc_board_model (.clk_sys(clk_sys),
    .cell_pin_out(cell_pin_out), .cell_pin_oe(cell_pin_oe), .ext_clock_pin(ext_clock_pin),
    .oe_pin_n(oe_pin_n), .cell_pin_in(cell_pin_in));

  // ----------------------------------------
  // Clock, tasks and closing
  // ----------------------------------------
  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Register state seen through the read-only status word
  task automatic chk_q(input logic [N-1:0] x);
    axi_rd(`OMC_ADDR_STAT);
    `CHK("q", {22'h0, x}, rd)
    `CHK("fb", x, reg_feedback)
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    wt(20000);
    n_errors++;
    finish_test();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  // Main sequence
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    {term_data_pos, term_data_neg, term_k, term_comb, cell_clock} = '0;
    {preset_term, reset_term, load_term, oe_term} = '0;
    term_data_fuse_pos = '0;
    term_data_fuse_neg = '1;
    {xb_out_term, xb_oe_term, extra_bidir_pin_zero_in, extra_bidir_pin_one_in} = '0;
    jv = '{10'h0ff, 10'h0f0, 10'h3c3};
    kv = '{10'h00f, 10'h30f, 10'h3c3};
    reset = 1'b1;
    wt(10);
    reset <= 1'b0;
    wt(2);
    `CHK("pin out", 10'h3ff, cell_pin_out)
    `CHK("oe", 10'h000, cell_pin_oe)
    chk_q(10'h000);
    axi_rd(32'h0000_0020);
    `CHK("resp", `OMC_RESP_SLVERR, rsp)
    axi_wr(32'h0000_0020, 32'h0000_0000);
    `CHK("bresp", `OMC_RESP_SLVERR, rsp)
    $display("test reset done");
    term_data_pos <= 10'h2a5;
    i_omc_board_model.ext_pulse();
    wt(10);
    chk_q(10'h2a5);
    `CHK("pin out", 10'h15a, cell_pin_out)
    term_data_fuse_neg <= '0;
    i_omc_board_model.ext_pulse();
    wt(10);
    chk_q(10'h000);
    term_data_fuse_neg <= '1;
    $display("test d register done");
    axi_wr(`OMC_ADDR_CFG, 32'h0000_03ff);
    `CHK("bresp", `OMC_RESP_OKAY, rsp)
    e = '0;
    for (int i = 0; i < 3; i++) begin
      term_data_pos <= jv[i];
      term_k <= kv[i];
      i_omc_board_model.ext_pulse();
      e = (jv[i] & ~kv[i]) | (~jv[i] & ~kv[i] & e) | (jv[i] & kv[i] & ~e);
      wt(10);
      chk_q(e);
    end
    term_k <= '0;
    $display("test jk register done");
    axi_wr(`OMC_ADDR_CFG, 32'h3ff0_0000);
    term_data_pos <= 10'h155;
    i_omc_board_model.ext_pulse();
    wt(10);
    chk_q(e);
    cell_clock <= '1;
    wt(4);
    cell_clock <= '0;
    wt(10);
    chk_q(10'h155);
    $display("test clock select done");
    preset_term <= '1;
    wt(6);
    chk_q(10'h3ff);
    reset_term <= '1;
    wt(6);
    chk_q(10'h3ff);
    preset_term <= '0;
    wt(6);
    chk_q(10'h000);
    reset_term <= '0;
    $display("test preset reset done");
    axi_wr(`OMC_ADDR_CFG, 32'h0000_0000);
    i_omc_board_model.set_pins(1'b1, 1'b1, 10'h1e1);
    load_term <= '1;
    term_data_pos <= '0;
    i_omc_board_model.ext_pulse();
    wt(10);
    chk_q(10'h1e1);
    `CHK("pin fb", 10'h1e1, pin_feedback)
    axi_rd(`OMC_ADDR_PIN);
    `CHK("pin", 32'h0000_01e1, rd)
    `CHK("oe", 10'h000, cell_pin_oe)
    load_term <= '0;
    $display("test load done");
    xb_oe_term <= 2'b10;
    xb_out_term <= 2'b01;
    extra_bidir_pin_one_in <= 1'b1;
    i_omc_board_model.set_pins(1'b0, 1'b0, 10'h000);
    wt(10);
    `CHK("oe", 10'h3ff, cell_pin_oe)
    `CHK("xb oe", 2'b10, {extra_bidir_pin_one_oe, extra_bidir_pin_zero_oe})
    `CHK("xb out", 2'b01, {extra_bidir_pin_one_out, extra_bidir_pin_zero_out})
    `CHK("xb fb", 2'b10, xb_feedback)
    i_omc_board_model.set_pins(1'b1, 1'b0, 10'h000);
    wt(10);
    `CHK("xb oe", 2'b10, {extra_bidir_pin_one_oe, extra_bidir_pin_zero_oe})
    axi_wr(`OMC_ADDR_CTL, 32'h0000_03ff);
    oe_term <= 10'h155;
    wt(10);
    `CHK("oe", 10'h155, cell_pin_oe)
    axi_wr(`OMC_ADDR_CTL, 32'h000f_fc00);
    wt(10);
    `CHK("oe", 10'h3ff, cell_pin_oe)
    $display("test enable done");
    axi_wr(`OMC_ADDR_CFG, 32'h000f_fc00);
    axi_wr(`OMC_ADDR_POL, 32'h0000_00f0);
    axi_rd(`OMC_ADDR_POL);
    `CHK("pol", 32'h0000_00f0, rd)
    term_comb <= 10'h3c3;
    wt(10);
    `CHK("pin out", 10'h333, cell_pin_out)
    axi_wr(`OMC_ADDR_CFG, 32'h0000_0000);
    wt(10);
    `CHK("pin out", 10'h21e, cell_pin_out)
    $display("test polarity done");
    finish_test();
  end
endmodule
